// ### verilog/fsr_pkg.sv
package fsr_pkg;

  // ****************************************************************
  // frame identifiers and lengths
  // ****************************************************************
  localparam logic [7:0] LONG_PREP_ID     = 8'h3C;   // protected form of the long preparing id
  localparam logic [5:0] RESP_FRAME_ID    = 6'h3D;   // indirect response identifier
  localparam logic [7:0] RESP_ID          = 8'h7D;   // RESP_FRAME_ID with its parity bits
  localparam logic [3:0] SHORT_DATA_LEN   = 4'h2;
  localparam logic [3:0] LONG_DATA_LEN    = 4'h8;
  localparam logic [3:0] RESP_DATA_LEN    = 4'h8;
  localparam int         RESP_FRAMES      = 2;
  localparam int         SHORT_ID_SEL_BIT = 5;       // cleared in every short preparing id

  // ****************************************************************
  // command contents
  // ****************************************************************
  localparam logic [6:0] FULL_STATUS_READ_CMD     = 7'h01;
  localparam logic [7:0] APPLICATION_COMMAND_BYTE = 8'h80;
  localparam logic [7:0] FILL_BYTE                = 8'hFF;
  localparam logic [7:0] CKSUM_RESET              = 8'h00;

  // ****************************************************************
  // latched flag positions
  // ****************************************************************
  localparam int NUM_FLAGS                = 12;
  localparam int FLG_THERMAL_WARNING      = 0;
  localparam int FLG_THERMAL_SHUTDOWN     = 1;
  localparam int FLG_SECOND_UNDERVOLTAGE  = 2;
  localparam int FLG_THIRD_UNDERVOLTAGE   = 3;
  localparam int FLG_UNDERVOLTAGE         = 4;
  localparam int FLG_ELECTRICAL_DEFECT    = 5;
  localparam int FLG_LOST_STEP            = 6;
  localparam int FLG_OVERCURRENT_COIL_X   = 7;
  localparam int FLG_OVERCURRENT_COIL_Y   = 8;
  localparam int FLG_SUPPLY_RESET         = 9;
  localparam int FLG_STALL                = 10;
  localparam int FLG_ABSOLUTE_STALL       = 11;
  localparam logic [11:0] FLAGS_RESET     = 12'h000;

  // ****************************************************************
  // host timing
  // ****************************************************************
  localparam logic [7:0] RESP_TIMEOUT_CYCLES = 8'h20;

  // two parity bits on top of a six-bit identifier
  function automatic logic [7:0] protect_id(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction : protect_id

  // command and address bytes carry a set top bit
  function automatic logic [7:0] mark_byte(input logic [6:0] v);
    return {1'b1, v};
  endfunction : mark_byte

endpackage : fsr_pkg

// ### verilog/fsr_link_if.sv
// ****************************************************************
// byte-level link between master and node
// ****************************************************************
interface fsr_link_if;
  logic       m_valid;   // master byte present
  logic       m_sof;     // master byte is a frame identifier
  logic [7:0] m_data;
  logic       s_valid;   // node response byte present
  logic [7:0] s_data;

  modport device (input m_valid, m_sof, m_data, output s_valid, s_data);
  modport host   (output m_valid, m_sof, m_data, input s_valid, s_data);
endinterface : fsr_link_if

// ### verilog/fsr_cksum.sv
module fsr_cksum
  import fsr_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // accumulate control
  input  wire logic       clear,
  input  wire logic       add,
  input  wire logic [7:0] data_in,
  // inverted running sum
  output wire logic [7:0] check_byte
);

  // ****************************************************************
  // classic sum with carry folded back
  // ****************************************************************
  logic [7:0] acc;
  logic [8:0] sum;

  assign sum = {1'b0, acc} + {1'b0, data_in};

  // fold cannot overflow: 0xFE plus carry tops out at 0xFF
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= CKSUM_RESET;
    end else if (clear) begin
      acc <= CKSUM_RESET;
    end else if (add) begin
      acc <= sum[7:0] + {7'h00, sum[8]};
    end
  end

  assign check_byte = ~acc;

endmodule : fsr_cksum

// ### verilog/fsr_device.sv
// Functional notes
// - executing command clears the twelve latched flags
// - answer is two frames on id 0x3D
// - missing second response request is harmless
// - short preparing frame followed by response header
// - long preparing frame followed by response header
// - short frame: dynamic id, command, address
// - long frame: 0x3C, app byte, command, address, fill
// - first response: address, currents, velocities, motion setup
// - first response bytes 5-8: flags, state, settings
// - second response: positions, stall settings, absolute stall
// - master may start with either preparing frame
module fsr_device
  import fsr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // link to master
  fsr_link_if.device       link,
  // node identity
  input  wire logic [6:0]  node_address,
  input  wire logic [4:0]  dynamic_id,
  // motor configuration
  input  wire logic [3:0]  run_current,
  input  wire logic [3:0]  hold_current,
  input  wire logic [3:0]  max_velocity,
  input  wire logic [3:0]  min_velocity,
  input  wire logic        accel_profile_select,
  input  wire logic [1:0]  microstep_resolution,
  input  wire logic        shaft_direction,
  input  wire logic [3:0]  acceleration,
  // live status
  input  wire logic [1:0]  temperature_info,
  input  wire logic [2:0]  motion_state,
  input  wire logic        external_switch_state,
  input  wire logic        pwm_frequency_select,
  input  wire logic        boost_current_disable,
  input  wire logic [1:0]  stabilization_time,
  input  wire logic        lin_timeout_error,
  input  wire logic        lin_data_error,
  input  wire logic        lin_header_error,
  input  wire logic        lin_bit_error,
  input  wire logic [3:0]  absolute_threshold,
  input  wire logic [2:0]  third_undervoltage_threshold,
  // positions and stall setup
  input  wire logic [15:0] actual_position,
  input  wire logic [15:0] target_position,
  input  wire logic [10:0] secure_position,
  input  wire logic [2:0]  fullstep_stall_enable,
  input  wire logic        full_duty_flag,
  input  wire logic [2:0]  stall_min_sample_count,
  input  wire logic        full_duty_stall_enable,
  input  wire logic        pwm_jitter_enable,
  // flag events, one-cycle pulses
  input  wire logic [11:0] flag_events,
  // state seen by the application
  output logic      [11:0] latched_flags,
  output logic             full_status_read_cmd,
  output logic      [1:0]  resp_pending
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  typedef enum logic [1:0] {DV_IDLE, DV_RX, DV_TX} fsr_dev_state_t;

  fsr_dev_state_t state;
  logic [3:0]     cnt;
  logic [3:0]     rx_len;
  logic           rx_long;
  logic           tx_sel;
  logic [7:0]     rxb  [0:7];
  logic [7:0]     snap [0:15];
  logic [7:0]     cur  [0:15];
  logic [11:0]    flags;
  logic           hdr;
  logic           id_ok;
  logic           is_long;
  logic           is_short;
  logic           is_resp;
  logic           dat;
  logic           complete;
  logic           cmd_ok;
  logic           exec;
  logic           ck_clear;
  logic           ck_add;
  logic [7:0]     ck_byte;
  logic [7:0]     ck_value;

  // ****************************************************************
  // header decode
  // ****************************************************************
  // headers with a broken parity are treated as foreign
  assign hdr      = link.m_valid && link.m_sof && (state != DV_TX);
  assign id_ok    = link.m_data == protect_id(link.m_data[5:0]);
  assign is_long  = id_ok && (link.m_data == LONG_PREP_ID);
  assign is_short = id_ok && !link.m_data[SHORT_ID_SEL_BIT] &&
                    (link.m_data[4:0] == dynamic_id);
  assign is_resp  = id_ok && (link.m_data == RESP_ID) && (resp_pending != 2'h0);

  // data bytes of a preparing frame, checksum last
  assign dat      = link.m_valid && !link.m_sof && (state == DV_RX);
  assign complete = dat && (cnt == rx_len);
  assign exec     = complete && (link.m_data == ck_value) && cmd_ok;

  // ****************************************************************
  // preparing frame contents
  // ****************************************************************
  // the fill bytes of the long frame are checked so a mangled frame is dropped
  always_comb begin
    cmd_ok = 1'b0;
    if (rx_long) begin
      cmd_ok = (rxb[0] == APPLICATION_COMMAND_BYTE) &&
               (rxb[1] == mark_byte(FULL_STATUS_READ_CMD)) &&
               (rxb[2] == mark_byte(node_address));
      for (int i = 3; i < 8; i++) begin
        if (rxb[i] != FILL_BYTE) begin
          cmd_ok = 1'b0;
        end
      end
    end else begin
      cmd_ok = (rxb[0] == mark_byte(FULL_STATUS_READ_CMD)) &&
               (rxb[1] == mark_byte(node_address));
    end
  end

  // ****************************************************************
  // response image, both frames
  // ****************************************************************
  always_comb begin
    cur[0]  = mark_byte(node_address);
    cur[1]  = {run_current, hold_current};
    cur[2]  = {max_velocity, min_velocity};
    cur[3]  = {accel_profile_select, microstep_resolution, shaft_direction,
               acceleration};
    cur[4]  = {flags[FLG_SUPPLY_RESET], flags[FLG_LOST_STEP],
               flags[FLG_ELECTRICAL_DEFECT], flags[FLG_UNDERVOLTAGE],
               flags[FLG_THERMAL_SHUTDOWN], flags[FLG_THERMAL_WARNING],
               temperature_info};
    cur[5]  = {motion_state, external_switch_state, flags[FLG_OVERCURRENT_COIL_X],
               flags[FLG_OVERCURRENT_COIL_Y], flags[FLG_STALL], 1'b0};
    cur[6]  = {pwm_frequency_select, boost_current_disable, stabilization_time,
               lin_timeout_error, lin_data_error, lin_header_error,
               lin_bit_error};
    cur[7]  = {absolute_threshold, flags[FLG_SECOND_UNDERVOLTAGE],
               third_undervoltage_threshold};
    cur[8]  = mark_byte(node_address);
    cur[9]  = actual_position[15:8];
    cur[10] = actual_position[7:0];
    cur[11] = target_position[15:8];
    cur[12] = target_position[7:0];
    cur[13] = secure_position[7:0];
    cur[14] = {fullstep_stall_enable, 1'b1, full_duty_flag,
               secure_position[10:8]};
    cur[15] = {flags[FLG_ABSOLUTE_STALL], 2'b00, stall_min_sample_count,
               full_duty_stall_enable, pwm_jitter_enable};
  end

  // snapshot at execution so both frames describe one instant
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        snap[i] <= 8'h00;
      end
    end else if (exec) begin
      for (int i = 0; i < 16; i++) begin
        snap[i] <= cur[i];
      end
    end
  end

  // ****************************************************************
  // latched flags
  // ****************************************************************
  // an event in the clearing cycle survives: set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= (exec ? FLAGS_RESET : flags) | flag_events;
    end
  end

  assign latched_flags = flags;

  // ****************************************************************
  // frame sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= DV_IDLE;
      cnt     <= 4'h0;
      rx_len  <= SHORT_DATA_LEN;
      rx_long <= 1'b0;
      tx_sel  <= 1'b0;
    end else begin
      case (state)
        DV_IDLE, DV_RX: begin
          if (hdr) begin
            cnt     <= 4'h0;
            rx_long <= is_long;
            rx_len  <= is_long ? LONG_DATA_LEN : SHORT_DATA_LEN;
            tx_sel  <= (resp_pending == 2'h2);
            // a header mid-frame aborts the frame in progress
            if (is_resp) begin
              state <= DV_TX;
            end else if (is_long || is_short) begin
              state <= DV_RX;
            end else begin
              state <= DV_IDLE;
            end
          end else if (dat) begin
            cnt <= cnt + 4'h1;
            if (complete) begin
              state <= DV_IDLE;
            end
          end
        end
        DV_TX: begin
          cnt <= cnt + 4'h1;
          if (cnt == RESP_DATA_LEN) begin
            state <= DV_IDLE;
          end
        end
        default: begin
          state <= DV_IDLE;
        end
      endcase
    end
  end

  // received preparing bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        rxb[i] <= 8'h00;
      end
    end else if (dat && (cnt < rx_len)) begin
      rxb[cnt[2:0]] <= link.m_data;
    end
  end

  // which frame the next response header collects
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_pending <= 2'h0;
    end else if (exec) begin
      resp_pending <= 2'h1;
    end else if (hdr && is_resp) begin
      // a skipped second request just waits; a new command restarts the pair
      resp_pending <= (resp_pending == 2'h1) ? 2'h2 : 2'h0;
    end
  end

  // execution strobe for the application
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full_status_read_cmd <= 1'b0;
    end else begin
      full_status_read_cmd <= exec;
    end
  end

  // ****************************************************************
  // response transmitter and checksum
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.s_valid <= 1'b0;
      link.s_data  <= 8'h00;
    end else if (state == DV_TX) begin
      link.s_valid <= 1'b1;
      link.s_data  <= (cnt < RESP_DATA_LEN) ? snap[{tx_sel, cnt[2:0]}] : ck_value;
    end else begin
      link.s_valid <= 1'b0;
    end
  end

  assign ck_clear = hdr;
  assign ck_add   = (dat && (cnt < rx_len)) || ((state == DV_TX) && (cnt < RESP_DATA_LEN));
  assign ck_byte  = (state == DV_TX) ? snap[{tx_sel, cnt[2:0]}] : link.m_data;

  fsr_cksum u_cksum (
    .clk        (clk),
    .rst_n      (rst_n),
    .clear      (ck_clear),
    .add        (ck_add),
    .data_in    (ck_byte),
    .check_byte (ck_value)
  );

endmodule : fsr_device

// ### verilog/fsr_host.sv
module fsr_host
  import fsr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // link to node
  fsr_link_if.host         link,
  // request
  input  wire logic        start,
  input  wire logic        use_long,
  input  wire logic        want_second,
  input  wire logic [6:0]  node_address,
  input  wire logic [4:0]  dynamic_id,
  // result
  output logic             busy,
  output logic             done,
  output logic      [1:0]  frame_ok,
  output logic      [63:0] first_frame,
  output logic      [63:0] second_frame
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  typedef enum logic [2:0] {H_IDLE, H_PREP, H_HDR, H_WAIT} fsr_host_state_t;

  fsr_host_state_t state;
  logic [3:0]      cnt;
  logic [7:0]      tmr;
  logic            sel;
  logic            r_long;
  logic            r_second;
  logic [6:0]      r_addr;
  logic [4:0]      r_dyn;
  logic [7:0]      pb [0:7];
  logic [3:0]      plen;
  logic            ck_clear;
  logic            ck_add;
  logic [7:0]      ck_byte;
  logic [7:0]      ck_value;

  assign plen = r_long ? LONG_DATA_LEN : SHORT_DATA_LEN;
  assign busy = (state != H_IDLE);

  // ****************************************************************
  // preparing frame bytes
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pb[i] = FILL_BYTE;
    end
    if (r_long) begin
      pb[0] = APPLICATION_COMMAND_BYTE;
      pb[1] = mark_byte(FULL_STATUS_READ_CMD);
      pb[2] = mark_byte(r_addr);
    end else begin
      pb[0] = mark_byte(FULL_STATUS_READ_CMD);
      pb[1] = mark_byte(r_addr);
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= H_IDLE;
      cnt          <= 4'h0;
      tmr          <= 8'h00;
      sel          <= 1'b0;
      r_long       <= 1'b0;
      r_second     <= 1'b0;
      r_addr       <= 7'h00;
      r_dyn        <= 5'h00;
      done         <= 1'b0;
      frame_ok     <= 2'b00;
      first_frame  <= 64'h0;
      second_frame <= 64'h0;
      link.m_valid <= 1'b0;
      link.m_sof   <= 1'b0;
      link.m_data  <= 8'h00;
    end else begin
      done         <= 1'b0;
      link.m_valid <= 1'b0;
      link.m_sof   <= 1'b0;
      case (state)
        H_IDLE: begin
          if (start) begin
            r_long   <= use_long;
            r_second <= want_second;
            r_addr   <= node_address;
            r_dyn    <= dynamic_id;
            frame_ok <= 2'b00;
            cnt      <= 4'h0;
            sel      <= 1'b0;
            state    <= H_PREP;
          end
        end
        H_PREP: begin
          link.m_valid <= 1'b1;
          cnt          <= cnt + 4'h1;
          if (cnt == 4'h0) begin
            link.m_sof  <= 1'b1;
            link.m_data <= r_long ? LONG_PREP_ID :
                           protect_id({1'b0, r_dyn});
          end else if (cnt <= plen) begin
            link.m_data <= pb[cnt[2:0] - 3'h1];
          end else begin
            link.m_data <= ck_value;
            state       <= H_HDR;
          end
        end
        H_HDR: begin
          link.m_valid <= 1'b1;
          link.m_sof   <= 1'b1;
          link.m_data  <= protect_id(RESP_FRAME_ID);
          cnt          <= 4'h0;
          tmr          <= 8'h00;
          state        <= H_WAIT;
        end
        H_WAIT: begin
          tmr <= tmr + 8'h01;
          if (link.s_valid) begin
            tmr <= 8'h00;
            cnt <= cnt + 4'h1;
            if (cnt < RESP_DATA_LEN) begin
              if (sel) begin
                second_frame <= {second_frame[55:0], link.s_data};
              end else begin
                first_frame <= {first_frame[55:0], link.s_data};
              end
            end else begin
              // a frame with a wrong checksum is reported as not ok
              frame_ok[sel] <= (link.s_data == ck_value);
              if (!sel && r_second) begin
                sel   <= 1'b1;
                state <= H_HDR;
              end else begin
                done  <= 1'b1;
                state <= H_IDLE;
              end
            end
          end else if (tmr == RESP_TIMEOUT_CYCLES) begin
            done  <= 1'b1;
            state <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // checksum over sent and received data bytes
  // ****************************************************************
  assign ck_clear = ((state == H_PREP) && (cnt == 4'h0)) || (state == H_HDR);
  assign ck_add   = ((state == H_PREP) && (cnt != 4'h0) && (cnt <= plen)) ||
                    ((state == H_WAIT) && link.s_valid && (cnt < RESP_DATA_LEN));
  assign ck_byte  = (state == H_PREP) ? pb[cnt[2:0] - 3'h1] : link.s_data;

  fsr_cksum u_cksum (
    .clk        (clk),
    .rst_n      (rst_n),
    .clear      (ck_clear),
    .add        (ck_add),
    .data_in    (ck_byte),
    .check_byte (ck_value)
  );

endmodule : fsr_host

// ### test/fsr_properties.sv
module fsr_properties
  import fsr_pkg::*;
(
  // link signals
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       m_valid,
  input wire logic       m_sof,
  input wire logic [7:0] m_data,
  input wire logic       s_valid,
  input wire logic [7:0] s_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****
  // frame pieces
  // ****
  sequence s_hdr; m_valid && m_sof && m_data == RESP_ID; endsequence
  sequence s_ans; s_valid[*8] ##1 s_valid ##1 !s_valid; endsequence
  sequence s_fill; (m_valid && m_data == FILL_BYTE)[*5]; endsequence
  property p_len; $rose(s_valid) |-> s_ans; endproperty
  a_len: assert property (p_len) else $error("answer length");
  // the header is seen one edge before the node raises s_valid, two before it is sampled high
  property p_cause;
    $rose(s_valid) |-> $past(m_valid && m_sof && m_data == RESP_ID, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without header");
  property p_mark; $rose(s_valid) |-> s_data[7]; endproperty
  a_mark: assert property (p_mark) else $error("address byte unmarked");
  property p_quiet; s_valid |-> !m_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("master talks over answer");
  // master keeps silent for the eight cycles after the response header
  property p_wait; s_hdr |=> (!m_valid)[*8]; endproperty
  a_wait: assert property (p_wait) else $error("master busy after header");
  property p_short; m_valid && m_sof && !m_data[5] |=> m_data == 8'h81 ##1 m_data[7]; endproperty
  a_short: assert property (p_short) else $error("short frame body");
  property p_long; m_valid && m_sof && m_data == LONG_PREP_ID
    |=> m_data == APPLICATION_COMMAND_BYTE ##1 m_data == 8'h81 ##1 m_data[7] ##1 s_fill;
  endproperty
  a_long: assert property (p_long) else $error("long frame body");
  property p_run; m_valid && m_sof && !m_data[5] |=> (m_valid && !m_sof)[*3]; endproperty
  a_run: assert property (p_run) else $error("short frame gap");
endmodule : fsr_properties

// ### test/fsr_bench.sv
module fsr_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ADDR = 7'h2A;
  localparam logic [4:0] DYN  = 5'h0B;
  // stimulus and results
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        st = 1'b0;
  logic        lg = 1'b0;
  logic        ws = 1'b0;
  logic        done;
  logic [1:0]  fok;
  logic [1:0]  rp;
  logic        hb;
  logic        xs;
  int          ex = 0;
  logic [6:0]  ha = ADDR;
  logic [11:0] ev = 12'h000;
  logic [11:0] lf;
  logic [63:0] f1q;
  logic [63:0] f2q;
  logic [96:0] v = 97'h1_A5C3_96F0_E1D2_B487_3C5A_69E1;
  int          bad_count = 0;
  int          total_checks = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  fsr_link_if u_fsr_link_if ();
  fsr_device u_fsr_device (.clk, .rst_n, .link(u_fsr_link_if), .node_address(ADDR),
    .dynamic_id(DYN), .run_current(v[96:93]), .hold_current(v[92:89]), .max_velocity(v[88:85]),
    .min_velocity(v[84:81]), .accel_profile_select(v[80]), .microstep_resolution(v[79:78]),
    .shaft_direction(v[77]), .acceleration(v[76:73]), .pwm_frequency_select(v[72]),
    .boost_current_disable(v[71]), .stabilization_time(v[70:69]), .lin_timeout_error(v[68]),
    .lin_data_error(v[67]), .lin_header_error(v[66]), .lin_bit_error(v[65]),
    .temperature_info(v[64:63]), .motion_state(v[62:60]), .external_switch_state(v[59]),
    .absolute_threshold(v[58:55]), .third_undervoltage_threshold(v[54:52]),
    .actual_position(v[51:36]), .target_position(v[35:20]), .secure_position(v[19:9]),
    .fullstep_stall_enable(v[8:6]), .full_duty_flag(v[5]), .stall_min_sample_count(v[4:2]),
    .full_duty_stall_enable(v[1]), .pwm_jitter_enable(v[0]), .flag_events(ev),
    .latched_flags(lf), .full_status_read_cmd(xs), .resp_pending(rp));
  fsr_host u_fsr_host (.clk, .rst_n, .link(u_fsr_link_if), .start(st), .use_long(lg),
    .want_second(ws), .node_address(ha), .dynamic_id(DYN), .busy(hb), .done, .frame_ok(fok),
    .first_frame(f1q), .second_frame(f2q));
  fsr_properties u_fsr_properties (.clk, .rst_n, .m_valid(u_fsr_link_if.m_valid),
    .m_sof(u_fsr_link_if.m_sof), .m_data(u_fsr_link_if.m_data),
    .s_valid(u_fsr_link_if.s_valid), .s_data(u_fsr_link_if.s_data));
  // execution strobes, counted on the falling edge where the pulse has settled
  always @(negedge clk) if (xs === 1'b1) ex++;
  // answers expected with every latched flag set
  function automatic logic [63:0] exp1(input logic [6:0] a);
    return {1'b1, a, v[96:73], 6'h3F, v[64:59], 3'h7, 1'b0, v[72:65], v[58:55], 1'b1, v[54:52]};
  endfunction : exp1
  function automatic logic [63:0] exp2(input logic [6:0] a);
    return {1'b1, a, v[51:20], v[16:9], v[8:6], 1'b1, v[5], v[19:17], 3'h4, v[4:0]};
  endfunction : exp2
  task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // set all flags, then run one read; fresh field values each time
  // k keeps the events up through the command, so set must beat clear
  task automatic rd(input logic l, input logic w, input logic [6:0] a, input logic k);
    int n;
    int e0;
    e0 = ex;
    @(posedge clk);
    ev <= 12'hFFF;
    v <= ~v;
    @(posedge clk);
    ev <= k ? 12'hFFF : 12'h000;
    st <= 1'b1;
    lg <= l;
    ws <= w;
    ha <= a;
    @(posedge clk);
    st <= 1'b0;
    n = 0;
    @(negedge clk);
    cmp("busy", 64'(1'b1), 64'(hb));
    do @(negedge clk); while (done !== 1'b1 && ++n < 400);
    cmp("done", 64'(1'b1), 64'(done));
    cmp("busy", 64'(1'b0), 64'(hb));
    cmp("strobe", 64'(a == ADDR), 64'(ex - e0));
    cmp("frame_ok", 64'((a == ADDR) ? {w, 1'b1} : 2'b00), 64'(fok));
    cmp("flags", 64'((a == ADDR && !k) ? 12'h000 : 12'hFFF), 64'(lf));
    if (a == ADDR) cmp("first", exp1(a), f1q);
    if (a == ADDR && w) cmp("second", exp2(a), f2q);
  endtask : rd
  task automatic t_long_first();
    rd(1'b1, 1'b0, ADDR, 1'b0);
    cmp("pending", 64'(2'd2), 64'(rp));
  endtask : t_long_first
  // start after reset; wrong address first, nothing pending yet
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(1'b0, 1'b1, ADDR ^ 7'h01, 1'b0);
    rd(1'b0, 1'b1, ADDR, 1'b0);
    t_long_first();
    rd(1'b0, 1'b0, ADDR, 1'b1);
    rd(1'b1, 1'b1, ADDR, 1'b0);
    cmp("pending", 64'(2'h0), 64'(rp));
    report_and_stop();
  end
  // hang guard, well beyond five reads
  initial begin
    #50000;
    bad_count++;
    report_and_stop();
  end
endmodule : fsr_bench
